// ---- common/thermal_head_dot_driver_params.svh ----
/*
 * Constants of the thermal head dot driver: timing, column layout and the
 * address window that clocks the element shift registers.
 * Assumes a 125 MHz core clock; included by bare name.
 */
`ifndef THERMAL_HEAD_DOT_DRIVER_PARAMS_SVH
`define THERMAL_HEAD_DOT_DRIVER_PARAMS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLOCK_PERIOD_NS   8
`define DOT_ON_TIME_NS    1700000
`define DOT_OFF_TIME_NS   600000
`define ODD_LATENCY_NS    20000
// on and off are least times: round up
`define DOT_ON_CYCLES     ((`DOT_ON_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define DOT_OFF_CYCLES    ((`DOT_OFF_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
// latency is a longest time: round down
`define ODD_LATENCY_CYCLES (`ODD_LATENCY_NS / `CLOCK_PERIOD_NS)

// ----------------------------------------------------------------
// column layout
// ----------------------------------------------------------------
`define ELEMENT_COUNT     40
`define HEAD_WIDTH        20
`define DRIVER_BITS       10
`define DRIVER_LAST_BIT   4'h9
`define DOTS_PER_ROW_LAST 3'h6
`define TIMER_WIDTH       18

// ----------------------------------------------------------------
// shift clock address window
// ----------------------------------------------------------------
`define ADDR_WIDTH        13
`define SHIFT_ADDR_LOW    13'h0800
`define SHIFT_ADDR_HIGH   13'h0C00
`define SHIFT_DATA_BIT    10
`define SHIFT_SEL_BIT     11
`define SHIFT_BLOCK_BIT   12
`define ADDR_IDLE         13'h0000

`endif

// ---- common/thermal_head_pkg.sv ----
/*
 * Types of the thermal head dot driver.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package thermal_head_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_SETUP = 3'b001,
        ST_CLKHI = 3'b010,
        ST_DRAIN = 3'b011,
        ST_WAIT  = 3'b100,
        ST_ON    = 3'b101,
        ST_OFF   = 3'b110
    } seq_state_t;

endpackage
`default_nettype wire

// ---- core/thermal_head_dot_driver.sv ----
/*
 * Thermal head dot driver: buffers 40-bit dot columns, shifts them into four
 * 10-bit element drivers, fires the common enable on dot strobe edges.
 * Assumes position pins are asynchronous and column words come on clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "thermal_head_dot_driver_params.svh"

module thermal_head_dot_driver #(
    parameter int ON_CYCLES  = `DOT_ON_CYCLES,
    parameter int OFF_CYCLES = `DOT_OFF_CYCLES
) (
    input  wire logic        clock,              // 125 MHz
    input  wire logic        rst,                // async, active high
    input  wire logic [39:0] columnData,         // bit 0 = element column 1
    input  wire logic        columnValid,        // column word offered
    output logic             columnReady,        // buffer has room
    input  wire logic        lineStart,          // motor line start pin
    input  wire logic        oddDotPosition,     // motor odd position pin
    input  wire logic        evenDotPosition,    // motor even position pin
    output logic             serialLineZero,     // driver for columns 31-40
    output logic             serialLineTwo,      // driver for columns 21-30
    output logic             serialLineFour,     // driver for columns 11-20
    output logic             serialLineSix,      // driver for columns 1-10
    output logic             shiftClock,         // driver shift clock
    output logic             driverOutputEnable, // common enable, high fires
    output logic             dotStrobe,          // merged position strobe
    output logic [2:0]       dotIndex,           // dot column within row
    output logic             rowDone             // pulse after seventh dot
);

    // ----------------------------------------------------------------
    // position pin synchronisers and merged strobe
    // ----------------------------------------------------------------
    logic [2:0] sync1_q, sync2_q, sync3_q, level_q;
    wire  [2:0] agree  = ~(sync2_q ^ sync3_q);
    wire  [2:0] levelD = (agree & sync3_q) | (~agree & level_q);
    wire  [2:0] rise   = levelD & ~level_q;
    wire        startEdge = rise[0];
    wire        oddEdge   = rise[1];
    wire        evenEdge  = rise[2];
    logic       dotStrobe_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            sync3_q <= 3'h0;
            level_q <= 3'h0;
        end else begin
            sync1_q <= {evenDotPosition, oddDotPosition, lineStart};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            level_q <= levelD;
        end
    end

    // odd pulls low, even or line start pulls high
    wire dotStrobeD = oddEdge ? 1'b0 : ((evenEdge | startEdge) ? 1'b1 : dotStrobe_q);
    wire strobeFell = dotStrobe_q & ~dotStrobeD;
    wire strobeRose = ~dotStrobe_q & dotStrobeD;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) dotStrobe_q <= 1'b1;
        else     dotStrobe_q <= dotStrobeD;
    end

    // ----------------------------------------------------------------
    // two-entry column buffer
    // ----------------------------------------------------------------
    logic [39:0] buf_q [2];
    logic        wrPtr_q, rdPtr_q;
    logic [1:0]  fill_q;
    logic        ready_q;
    wire         bufValid = (fill_q != 2'h0);
    wire         push     = columnValid & ready_q;
    logic        pop;
    wire  [1:0]  fillD    = fill_q + {1'b0, push} - {1'b0, pop};

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wrPtr_q <= 1'b0;
            rdPtr_q <= 1'b0;
            fill_q  <= 2'h0;
            ready_q <= 1'b1;
        end else begin
            wrPtr_q <= wrPtr_q ^ push;
            rdPtr_q <= rdPtr_q ^ pop;
            fill_q  <= fillD;
            ready_q <= (fillD != 2'h2);
        end
    end

    always_ff @(posedge clock) begin
        if (push) buf_q[wrPtr_q] <= columnData;
    end

    // ----------------------------------------------------------------
    // dot sequencer
    // ----------------------------------------------------------------
    thermal_head_pkg::seq_state_t state_q, stateD;
    logic [`TIMER_WIDTH-1:0] timer_q;
    logic [3:0]              bitIdx_q;
    logic [39:0]             shiftReg_q;
    logic                    expectLow_q;
    logic                    enable_q;
    logic [`ADDR_WIDTH-1:0]  accessAddr_q;
    logic                    access_q;
    logic                    shiftClock_q;
    logic [3:0]              serial_q;
    logic [2:0]              dotIndex_q;
    logic                    rowDone_q;

    // shifts each 10-bit driver group up by one, top bit leaves first
    function automatic logic [39:0] shiftGroups(input logic [39:0] x);
        shiftGroups = {x[38:30], 1'b0, x[28:20], 1'b0, x[18:10], 1'b0, x[8:0], 1'b0};
    endfunction

    wire lastBit  = (bitIdx_q == `DRIVER_LAST_BIT);
    wire onDone   = (timer_q == `TIMER_WIDTH'(ON_CYCLES - 1));
    wire offDone  = (timer_q == `TIMER_WIDTH'(OFF_CYCLES - 1));
    wire fireNow  = expectLow_q ? strobeFell : strobeRose;
    assign pop    = (state_q == thermal_head_pkg::ST_IDLE) & bufValid;
    wire lastDot  = (dotIndex_q == `DOTS_PER_ROW_LAST);
    wire addrHit  = access_q & accessAddr_q[`SHIFT_SEL_BIT]
                  & ~accessAddr_q[`SHIFT_BLOCK_BIT];

    always_comb begin
        stateD = state_q;
        unique case (state_q)
            thermal_head_pkg::ST_IDLE:  if (bufValid) stateD = thermal_head_pkg::ST_SETUP;
            thermal_head_pkg::ST_SETUP: stateD = thermal_head_pkg::ST_CLKHI;
            thermal_head_pkg::ST_CLKHI: stateD = lastBit ? thermal_head_pkg::ST_DRAIN
                                                         : thermal_head_pkg::ST_SETUP;
            thermal_head_pkg::ST_DRAIN: stateD = thermal_head_pkg::ST_WAIT;
            thermal_head_pkg::ST_WAIT:  if (fireNow) stateD = thermal_head_pkg::ST_ON;
            thermal_head_pkg::ST_ON:    if (onDone) stateD = thermal_head_pkg::ST_OFF;
            thermal_head_pkg::ST_OFF:   if (offDone) stateD = thermal_head_pkg::ST_IDLE;
            default:                    stateD = thermal_head_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q  <= thermal_head_pkg::ST_IDLE;
            timer_q  <= '0;
            bitIdx_q <= 4'h0;
        end else begin
            state_q  <= stateD;
            timer_q  <= (state_q != stateD) ? '0 : timer_q + 1'b1;
            if (state_q == thermal_head_pkg::ST_CLKHI)
                bitIdx_q <= lastBit ? 4'h0 : bitIdx_q + 4'h1;
        end
    end

    // column bits 39..30 leave on line zero, 9..0 on line six
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shiftReg_q <= 40'h00_0000_0000;
            serial_q   <= 4'h0;
        end else if (pop) begin
            shiftReg_q <= buf_q[rdPtr_q];
        end else if (state_q == thermal_head_pkg::ST_SETUP) begin
            serial_q   <= {shiftReg_q[39], shiftReg_q[29], shiftReg_q[19], shiftReg_q[9]};
            shiftReg_q <= shiftGroups(shiftReg_q);
        end
    end

    // high then low address access per bit makes one shift clock edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            accessAddr_q <= `ADDR_IDLE;
            access_q     <= 1'b0;
            shiftClock_q <= 1'b0;
        end else begin
            access_q     <= (state_q == thermal_head_pkg::ST_SETUP)
                          | (state_q == thermal_head_pkg::ST_CLKHI)
                          | (state_q == thermal_head_pkg::ST_DRAIN);
            accessAddr_q <= (state_q == thermal_head_pkg::ST_SETUP) ? `SHIFT_ADDR_HIGH
                                                                    : `SHIFT_ADDR_LOW;
            if (addrHit) shiftClock_q <= accessAddr_q[`SHIFT_DATA_BIT];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            enable_q    <= 1'b0;
            expectLow_q <= 1'b1;
            dotIndex_q  <= 3'h0;
            rowDone_q   <= 1'b0;
        end else begin
            enable_q  <= (stateD == thermal_head_pkg::ST_ON);
            rowDone_q <= 1'b0;
            if (startEdge) begin
                expectLow_q <= 1'b1;
                dotIndex_q  <= 3'h0;
            end else if (state_q == thermal_head_pkg::ST_WAIT && fireNow) begin
                expectLow_q <= ~expectLow_q;
                dotIndex_q  <= lastDot ? 3'h0 : dotIndex_q + 3'h1;
                rowDone_q   <= lastDot;
            end
        end
    end

    assign columnReady        = ready_q;
    assign serialLineZero     = serial_q[3];
    assign serialLineTwo      = serial_q[2];
    assign serialLineFour     = serial_q[1];
    assign serialLineSix      = serial_q[0];
    assign shiftClock         = shiftClock_q;
    assign driverOutputEnable = enable_q;
    assign dotStrobe          = dotStrobe_q;
    assign dotIndex           = dotIndex_q;
    assign rowDone            = rowDone_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [`TIMER_WIDTH-1:0] offRun_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst)           offRun_q <= {`TIMER_WIDTH{1'b1}};
        else if (enable_q) offRun_q <= '0;
        else if (offRun_q != {`TIMER_WIDTH{1'b1}}) offRun_q <= offRun_q + 1'b1;
    end

    sequence s_bit_setup;
        state_q == thermal_head_pkg::ST_SETUP;
    endsequence
    sequence s_bit_clock;
        s_bit_setup ##1 state_q == thermal_head_pkg::ST_CLKHI;
    endsequence

    a_enable_on_width: assert property (@(posedge clock) disable iff (rst)
        $fell(enable_q) |-> $past(timer_q) == `TIMER_WIDTH'(ON_CYCLES - 1))
        else $error("enable on time wrong");
    a_enable_off_gap: assert property (@(posedge clock) disable iff (rst)
        $rose(enable_q) |-> offRun_q >= `TIMER_WIDTH'(OFF_CYCLES - 1))
        else $error("enable off gap too short");
    a_shift_when_off: assert property (@(posedge clock) disable iff (rst)
        enable_q |-> $stable(shiftClock_q) && !access_q)
        else $error("shift clock moved while enabled");
    a_loaded_first: assert property (@(posedge clock) disable iff (rst)
        $rose(enable_q) |-> $past(state_q) == thermal_head_pkg::ST_WAIT && bitIdx_q == 4'h0)
        else $error("enable rose before full load");
    a_odd_latency: assert property (@(posedge clock) disable iff (rst)
        (state_q == thermal_head_pkg::ST_WAIT && expectLow_q && strobeFell)
        |-> ##1 enable_q)
        else $error("odd dot not fired in time");
    a_strobe_merge: assert property (@(posedge clock) disable iff (rst)
        oddEdge |=> !dotStrobe_q)
        else $error("odd position did not pull strobe low");
    a_row_wrap: assert property (@(posedge clock) disable iff (rst)
        rowDone_q |-> dotIndex_q == 3'h0 && $past(dotIndex_q) == `DOTS_PER_ROW_LAST)
        else $error("row not seven dots");
    a_clock_decode: assert property (@(posedge clock) disable iff (rst)
        $rose(shiftClock_q) |-> $past(addrHit) && $past(accessAddr_q[`SHIFT_DATA_BIT]))
        else $error("shift clock outside address window");
    a_line_map: assert property (@(posedge clock) disable iff (rst)
        s_bit_clock |-> serial_q[3] == $past(shiftReg_q[39]) && serial_q[0] == $past(shiftReg_q[9]))
        else $error("serial line mapping wrong");
    a_bit_edge: assert property (@(posedge clock) disable iff (rst)
        s_bit_clock |=> shiftClock_q)
        else $error("no shift edge for bit");

endmodule
`default_nettype wire

// ---- dv/motor_head_model.sv ----
/*
 * Model of the print mechanism: motor position pins and four 10-bit
 * element shift registers latched when the common enable rises.
 * Assumes the 125 MHz clock of the dot driver.
 */
`timescale 1ns/1ps
`default_nettype none
module motor_head_model (
    input  wire logic        clock,              // core clock
    input  wire logic        serialLineZero,     // columns 31-40
    input  wire logic        serialLineTwo,      // columns 21-30
    input  wire logic        serialLineFour,     // columns 11-20
    input  wire logic        serialLineSix,      // columns 1-10
    input  wire logic        shiftClock,         // shift on rise
    input  wire logic        driverOutputEnable, // elements fire
    output logic             lineStart,          // line start pin
    output logic             oddDotPosition,     // odd position pin
    output logic             evenDotPosition     // even position pin
);
    // ----------------------------------------------------------------
    // element drivers
    // ----------------------------------------------------------------
    logic [9:0]  regZero, regTwo, regFour, regSix;
    logic [39:0] image;
    logic        scPrev = 1'b0;
    int          shifts = 0;
    int          offGap = 100000;
    int          gapAtShift = 100000;
    int          badShift = 0;
    int          holdCnt = 0;
    int          sel = 0;
    always @(negedge clock) begin
        if (shiftClock === 1'b1 && scPrev === 1'b0) begin
            if (shifts == 0) gapAtShift = offGap;
            regZero = {regZero[8:0], serialLineZero};
            regTwo = {regTwo[8:0], serialLineTwo};
            regFour = {regFour[8:0], serialLineFour};
            regSix = {regSix[8:0], serialLineSix};
            shifts++;
            if (driverOutputEnable !== 1'b0) badShift++;
        end
        scPrev = shiftClock;
        offGap = (driverOutputEnable === 1'b1) ? 0 : offGap + 1;
    end
    // snapshot of the drivers as the elements fire
    always @(posedge driverOutputEnable) begin
        image = {regZero, regTwo, regFour, regSix};
        shifts = 0;
    end
    // ----------------------------------------------------------------
    // position pins, idle low, pulse of five cycles
    // ----------------------------------------------------------------
    assign lineStart = (holdCnt != 0) && (sel == 0);
    assign oddDotPosition = (holdCnt != 0) && (sel == 1);
    assign evenDotPosition = (holdCnt != 0) && (sel == 2);
    always @(posedge clock) begin
        if (holdCnt != 0) holdCnt <= holdCnt - 1;
    end
    task automatic pulse(input int which);
        @(posedge clock);
        sel <= which;
        holdCnt <= 5;
    endtask
endmodule
`default_nettype wire

// ---- dv/thermal_head_dot_driver_tb_top.sv ----
/*
 * Testbench of the thermal head dot driver: column stream, dot timing,
 * element mapping and row counting.
 * Assumes the motor_head_model partner; run with short on and off counts.
 */
`timescale 1ns/1ps
`default_nettype none
`include "thermal_head_dot_driver_params.svh"
`define CHECK(nm, ex, got) begin checkCount++; if ((got) !== (ex)) begin \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); nFail++; end end
module thermal_head_dot_driver_tb_top;
    localparam int ON = 20;
    localparam int OFF = 40;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [39:0] columnData = 40'h0;
    logic        columnValid = 1'b0;
    wire         columnReady, lineStart, oddDotPosition, evenDotPosition;
    wire         serialLineZero, serialLineTwo, serialLineFour, serialLineSix;
    wire         shiftClock, driverOutputEnable, dotStrobe, rowDone;
    wire [2:0]   dotIndex;
    int          nFail = 0;
    int          checkCount = 0;
    int          rowCount = 0;
    logic [39:0] expQ[$];
    thermal_head_dot_driver #(.ON_CYCLES(ON), .OFF_CYCLES(OFF)) thermal_head_dot_driver_inst (
        .clock(clock), .rst(rst), .columnData(columnData), .columnValid(columnValid),
        .columnReady(columnReady), .lineStart(lineStart), .oddDotPosition(oddDotPosition),
        .evenDotPosition(evenDotPosition), .serialLineZero(serialLineZero),
        .serialLineTwo(serialLineTwo), .serialLineFour(serialLineFour),
        .serialLineSix(serialLineSix), .shiftClock(shiftClock),
        .driverOutputEnable(driverOutputEnable), .dotStrobe(dotStrobe),
        .dotIndex(dotIndex), .rowDone(rowDone));
    motor_head_model motor_head_model_inst (
        .clock(clock), .serialLineZero(serialLineZero), .serialLineTwo(serialLineTwo),
        .serialLineFour(serialLineFour), .serialLineSix(serialLineSix),
        .shiftClock(shiftClock), .driverOutputEnable(driverOutputEnable),
        .lineStart(lineStart), .oddDotPosition(oddDotPosition),
        .evenDotPosition(evenDotPosition));
    initial begin
        forever #4 clock = ~clock;
    end
    always @(negedge clock) begin
        if (rowDone === 1'b1) rowCount++;
    end
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    function automatic logic [39:0] col(input int i);
        return 40'hC35A960F1E ^ (40'h0100401004 * 40'(i));
    endfunction
    task automatic push(input logic [39:0] d);
        @(posedge clock);
        columnData <= d;
        columnValid <= 1'b1;
        expQ.push_back(d);
        for (int k = 0; k < 400; k++) begin
            @(negedge clock);
            if (columnReady === 1'b1) break;
        end
        @(posedge clock);
        columnValid <= 1'b0;
    endtask
    task automatic dot(input logic isOdd);
        int          lat;
        int          onLen;
        logic [39:0] want;
        for (int k = 0; k < 300 && motor_head_model_inst.shifts != 10; k++) @(negedge clock);
        repeat (3) @(negedge clock);
        `CHECK("bits loaded", 10, motor_head_model_inst.shifts)
        `CHECK("off gap", 1'b1, motor_head_model_inst.gapAtShift >= OFF)
        motor_head_model_inst.pulse(isOdd ? 1 : 2);
        lat = 0;
        while (driverOutputEnable !== 1'b1 && lat < 40) begin
            @(negedge clock);
            lat++;
        end
        `CHECK("fire latency", 1'b1, lat <= `ODD_LATENCY_CYCLES && lat < 40)
        `CHECK("strobe level", !isOdd, dotStrobe)
        want = expQ.pop_front();
        `CHECK("element image", want, motor_head_model_inst.image)
        onLen = 0;
        while (driverOutputEnable === 1'b1 && onLen < ON + 5) begin
            @(negedge clock);
            onLen++;
        end
        `CHECK("on span", 1'b1, onLen >= ON - 1 && onLen <= ON + 1)
        `CHECK("shift while on", 0, motor_head_model_inst.badShift)
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checkCount, nFail);
        if (nFail == 0 && checkCount > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        @(negedge clock);
        `CHECK("reset outputs", 12'h810, {columnReady, serialLineZero, serialLineTwo,
            serialLineFour, serialLineSix, shiftClock, driverOutputEnable, dotStrobe,
            dotIndex, rowDone})
    endtask
    task automatic t_buffer;
        for (int i = 0; i < 3; i++) push(col(i));
        repeat (2) @(negedge clock);
        `CHECK("buffer full", 1'b0, columnReady)
    endtask
    task automatic t_row;
        for (int i = 0; i < 7; i++) begin
            `CHECK("dot index", 3'(i), dotIndex)
            dot(i % 2 == 0);
            push(col(3 + i));
        end
        repeat (5) @(negedge clock);
        `CHECK("row done", 1, rowCount)
        `CHECK("index wrap", 3'h0, dotIndex)
    endtask
    task automatic t_line_start;
        @(negedge clock);
        motor_head_model_inst.pulse(0);
        repeat (12) @(negedge clock);
        `CHECK("start strobe", 1'b1, dotStrobe)
        `CHECK("start index", 3'h0, dotIndex)
        dot(1'b1);
    endtask
    initial begin
        t_reset();
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_buffer();
        t_row();
        t_line_start();
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge clock);
        nFail++;
        stop_test();
    end
endmodule
`default_nettype wire
